// >>> common/xag_defs.svh
// constants for the address generation datapath
`ifndef XAG_DEFS_SVH
`define XAG_DEFS_SVH
`define XAG_NUM_GPR 8
`define XAG_NUM_SEG 6
`define XAG_SP_IDX 3'h4
`define XAG_REAL_WIDTH 21
`define XAG_REAL_SHIFT 4
`define XAG_IO_WIDTH 16
`define XAG_SIZE_BYTE 2'h0
`define XAG_SIZE_WORD 2'h1
`define XAG_SIZE_DWORD 2'h2
`endif

// >>> common/xag_pkg.sv
// types for the address generation datapath
package xag_pkg;
  typedef enum logic [3:0] {
    XAG_DIRECT,
    XAG_REG_IND,
    XAG_BASED,
    XAG_INDEX,
    XAG_SCALED_INDEX,
    XAG_BASED_INDEX,
    XAG_BASED_SCALED_INDEX,
    XAG_BASED_INDEX_DISP,
    XAG_BASED_SCALED_INDEX_DISP
  } xag_mode_e;
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    logic [11:0] attr;
  } xag_desc_s;
endpackage

// >>> common/xag_seg_if.sv
// segment cache write and read carrier
`timescale 1ns/1ps
`default_nettype none
interface xag_seg_if;
  logic wrEn;
  logic [2:0] wrSeg;
  logic [15:0] wrSel;
  xag_pkg::xag_desc_s wrDesc;
  logic [2:0] rdSeg;
  logic [15:0] rdSel;
  xag_pkg::xag_desc_s rdDesc;
  modport owner (output wrEn, output wrSeg, output wrSel, output wrDesc, output rdSeg,
                 input rdSel, input rdDesc);
  modport cache (input wrEn, input wrSeg, input wrSel, input wrDesc, input rdSeg,
                 output rdSel, output rdDesc);
endinterface
`default_nettype wire

// >>> verilog/xag_seg_cache.sv
// six segment registers with hidden descriptor cache
`timescale 1ns/1ps
`default_nettype none
`include "xag_defs.svh"
module xag_seg_cache (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // access
  xag_seg_if.cache seg
);
  logic [15:0] selR [`XAG_NUM_SEG];
  xag_pkg::xag_desc_s descR [`XAG_NUM_SEG];
  logic [2:0] rdSegR;

  // selector and descriptor captured together on a load
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `XAG_NUM_SEG; i++) begin
        selR[i] <= 16'h0000;
        descR[i] <= '0;
      end
    end else if (seg.wrEn && seg.wrSeg < 3'(`XAG_NUM_SEG)) begin
      selR[seg.wrSeg] <= seg.wrSel;
      descR[seg.wrSeg] <= seg.wrDesc;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdSegR <= 3'h0;
    end else begin
      rdSegR <= seg.rdSeg;
    end
  end

  // read index is registered and the data read combinationally from it, so the base is ready with the operands
  assign seg.rdSel = (rdSegR < 3'(`XAG_NUM_SEG)) ? selR[rdSegR] : 16'h0000;
  assign seg.rdDesc = (rdSegR < 3'(`XAG_NUM_SEG)) ? descR[rdSegR] : '0;
endmodule
`default_nettype wire

// >>> verilog/xag_gpr_file.sv
// eight general registers with two read ports
`timescale 1ns/1ps
`default_nettype none
`include "xag_defs.svh"
module xag_gpr_file #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // write port from the pipeline
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // read ports, data registered
  input wire logic [2:0] baseIdx,
  input wire logic [2:0] indexIdx,
  output logic [WIDTH-1:0] baseData,
  output logic [WIDTH-1:0] indexData
);
  logic [WIDTH-1:0] regR [`XAG_NUM_GPR];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `XAG_NUM_GPR; i++) begin
        regR[i] <= '0;
      end
    end else if (wrEn) begin
      regR[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      baseData <= '0;
      indexData <= '0;
    end else begin
      baseData <= regR[baseIdx];
      // stack pointer slot reads as no index
      indexData <= (indexIdx == `XAG_SP_IDX) ? '0 : regR[indexIdx];
    end
  end
endmodule
`default_nettype wire

// >>> verilog/xag_addr_gen.sv
// address generation datapath top
`timescale 1ns/1ps
`default_nettype none
`include "xag_defs.svh"
module xag_addr_gen #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register file writes from the pipeline
  input wire logic gprWrEn,
  input wire logic [2:0] gprWrIdx,
  input wire logic [31:0] gprWrData,
  // segment selector loads with fetched descriptor
  input wire logic segLoad,
  input wire logic [2:0] segLoadIdx,
  input wire logic [15:0] segLoadSel,
  input wire logic [31:0] segLoadBase,
  input wire logic [31:0] segLoadLimit,
  input wire logic [11:0] segLoadAttr,
  // address request
  input wire logic reqValid,
  input wire logic [3:0] reqMode,
  input wire logic [2:0] baseIdx,
  input wire logic [2:0] indexIdx,
  input wire logic [1:0] scaleSel,
  input wire logic [31:0] displacementValue,
  input wire logic [2:0] segIdx,
  input wire logic [1:0] accSize,
  input wire logic ioAccess,
  // mode controls
  input wire logic protMode,
  input wire logic pagingEn,
  // results
  output logic resValid,
  output logic [31:0] offsetAddress,
  output logic [31:0] linearAddr,
  output logic [31:0] physAddr,
  output logic toPaging,
  output logic [3:0] byteEnable,
  output logic [15:0] ioPort,
  output logic badMode,
  output logic [15:0] curSelector,
  output logic [31:0] curLimit
);
  xag_seg_if seg ();
  logic [31:0] baseVal;
  logic [31:0] indexVal;
  logic validR;
  xag_pkg::xag_mode_e modeR;
  logic modeBadR;
  logic [1:0] scaleR;
  logic [31:0] dispR;
  logic [1:0] sizeR;
  logic ioR;
  logic protR;
  logic pagingR;
  logic useBase;
  logic useIndex;
  logic useScale;
  logic useDisp;
  logic [31:0] scaledIdx;
  logic [31:0] eaSum;
  logic [20:0] realSum;
  logic [31:0] linSum;

  xag_gpr_file #(.WIDTH(32)) u_gpr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(gprWrEn),
    .wrIdx(gprWrIdx),
    .wrData(gprWrData),
    .baseIdx(baseIdx),
    .indexIdx(indexIdx),
    .baseData(baseVal),
    .indexData(indexVal)
  );

  assign seg.wrEn = segLoad;
  assign seg.wrSeg = segLoadIdx;
  assign seg.wrSel = segLoadSel;
  assign seg.wrDesc = '{base: segLoadBase, limit: segLoadLimit, attr: segLoadAttr};
  assign seg.rdSeg = segIdx;

  xag_seg_cache u_seg (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .seg(seg.cache)
  );

  // operand capture, aligned with the register file read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      validR <= 1'b0;
      modeR <= xag_pkg::XAG_DIRECT;
      modeBadR <= 1'b0;
      scaleR <= 2'h0;
      dispR <= 32'h0000_0000;
      sizeR <= `XAG_SIZE_BYTE;
      ioR <= 1'b0;
    end else begin
      validR <= reqValid;
      modeBadR <= reqMode > 4'(xag_pkg::XAG_BASED_SCALED_INDEX_DISP);
      modeR <= xag_pkg::xag_mode_e'(reqMode);
      scaleR <= scaleSel;
      dispR <= displacementValue;
      sizeR <= accSize;
      ioR <= ioAccess;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      protR <= 1'b0;
      pagingR <= 1'b0;
    end else begin
      protR <= protMode;
      pagingR <= pagingEn;
    end
  end

  // component selection per addressing mode
  always_comb begin
    useBase = 1'b0;
    useIndex = 1'b0;
    useScale = 1'b0;
    useDisp = 1'b0;
    if (!modeBadR) begin
      unique case (modeR)
        xag_pkg::XAG_DIRECT: begin
          useDisp = 1'b1;
        end
        xag_pkg::XAG_REG_IND: begin
          useBase = 1'b1;
        end
        xag_pkg::XAG_BASED: begin
          useBase = 1'b1;
          useDisp = 1'b1;
        end
        xag_pkg::XAG_INDEX: begin
          useIndex = 1'b1;
          useDisp = 1'b1;
        end
        xag_pkg::XAG_SCALED_INDEX: begin
          useIndex = 1'b1;
          useScale = 1'b1;
          useDisp = 1'b1;
        end
        xag_pkg::XAG_BASED_INDEX: begin
          useBase = 1'b1;
          useIndex = 1'b1;
        end
        xag_pkg::XAG_BASED_SCALED_INDEX: begin
          useBase = 1'b1;
          useIndex = 1'b1;
          useScale = 1'b1;
        end
        xag_pkg::XAG_BASED_INDEX_DISP: begin
          useBase = 1'b1;
          useIndex = 1'b1;
          useDisp = 1'b1;
        end
        xag_pkg::XAG_BASED_SCALED_INDEX_DISP: begin
          useBase = 1'b1;
          useIndex = 1'b1;
          useScale = 1'b1;
          useDisp = 1'b1;
        end
        default: begin
          useBase = 1'b0;
        end
      endcase
    end
  end

  // unscaled modes force a factor of one
  assign scaledIdx = useScale ? (indexVal << scaleR) : indexVal;
  // 32-bit add wraps by construction
  assign eaSum = (useBase ? baseVal : 32'h0000_0000)
               + (useIndex ? scaledIdx : 32'h0000_0000)
               + (useDisp ? dispR : 32'h0000_0000);
  // carry out of bit 19 kept as bit 20 for the 64 KB above one megabyte
  assign realSum = {5'h00, seg.rdSel} * 21'h000010 + {5'h00, eaSum[15:0]};
  assign linSum = seg.rdDesc.base + eaSum;

  always_comb begin
    resValid = validR;
    offsetAddress = eaSum;
    if (protR) begin
      linearAddr = linSum;
    end else begin
      linearAddr = {11'h000, realSum};
    end
    // paging only exists in protected mode
    toPaging = validR && protR && pagingR;
    physAddr = toPaging ? 32'h0000_0000 : linearAddr;
    // port number shows only on io accesses so memory cycles leave the port bus quiet
    ioPort = ioR ? eaSum[15:0] : 16'h0000;
    badMode = validR && modeBadR;
    curSelector = seg.rdSel;
    curLimit = seg.rdDesc.limit;
  end

  // lanes counted from the lowest-order byte at the given address
  always_comb begin
    unique case (sizeR)
      `XAG_SIZE_BYTE: byteEnable = 4'h1 << physAddr[1:0];
      `XAG_SIZE_WORD: byteEnable = 4'h3 << physAddr[1:0];
      // lanes past the top belong to the next word and are dropped here
      default: byteEnable = 4'hf << physAddr[1:0];
    endcase
  end

  property p_spNoIndex;
    @(posedge mclk) disable iff (sys_rst)
      (indexIdx == `XAG_SP_IDX) |=> (indexVal == 32'h0000_0000);
  endproperty
  a_spNoIndex: assert property (p_spNoIndex) else $error("stack pointer used as index");

  property p_fullForm;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_BASED_SCALED_INDEX_DISP)
        |-> offsetAddress == baseVal + (indexVal << scaleR) + dispR;
  endproperty
  a_fullForm: assert property (p_fullForm) else $error("full form offset wrong");

  property p_direct;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_DIRECT) |-> offsetAddress == dispR;
  endproperty
  a_direct: assert property (p_direct) else $error("direct offset wrong");

  property p_realRange;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !protR) |-> (physAddr < 32'h0011_0000);
  endproperty
  a_realRange: assert property (p_realRange) else $error("real mode address too high");

  property p_realCalc;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !protR) |-> physAddr == {12'h000, seg.rdSel, 4'h0} + {16'h0000, eaSum[15:0]};
  endproperty
  a_realCalc: assert property (p_realCalc) else $error("real mode address wrong");

  property p_protLin;
    @(posedge mclk) disable iff (sys_rst)
      (validR && protR) |-> linearAddr == 32'(seg.rdDesc.base + offsetAddress);
  endproperty
  a_protLin: assert property (p_protLin) else $error("linear address wrong");

  property p_noPaging;
    @(posedge mclk) disable iff (sys_rst)
      (validR && protR && !pagingR) |-> (physAddr == linearAddr && !toPaging);
  endproperty
  a_noPaging: assert property (p_noPaging) else $error("linear not passed through");

  property p_latency;
    @(posedge mclk) disable iff (sys_rst)
      reqValid |=> resValid;
  endproperty
  a_latency: assert property (p_latency) else $error("result late");

  property p_segLoad;
    @(posedge mclk) disable iff (sys_rst)
      (segLoad && segLoadIdx < 3'h6 && segIdx == segLoadIdx) ##1 (!segLoad && segIdx == $past(segIdx))
        |=> (curSelector == $past(segLoadSel, 2));
  endproperty
  a_segLoad: assert property (p_segLoad) else $error("selector not held");

  property p_pagingOn;
    @(posedge mclk) disable iff (sys_rst)
      (validR && protR && pagingR) |-> (toPaging && physAddr == 32'h0000_0000);
  endproperty
  a_pagingOn: assert property (p_pagingOn) else $error("paged address not handed on");

  property p_realNoPaging;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !protR) |-> (!toPaging && physAddr == linearAddr);
  endproperty
  a_realNoPaging: assert property (p_realNoPaging) else $error("real mode sent to paging");

  property p_realZeroExt;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !protR) |-> (linearAddr[31:21] == 11'h000);
  endproperty
  a_realZeroExt: assert property (p_realZeroExt) else $error("real mode upper bits set");

  property p_regInd;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_REG_IND)
        |-> offsetAddress == baseVal;
  endproperty
  a_regInd: assert property (p_regInd) else $error("register indirect offset wrong");

  property p_based;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_BASED)
        |-> offsetAddress == baseVal + dispR;
  endproperty
  a_based: assert property (p_based) else $error("based offset wrong");

  property p_scaledIndex;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_SCALED_INDEX)
        |-> offsetAddress == (indexVal << scaleR) + dispR;
  endproperty
  a_scaledIndex: assert property (p_scaledIndex) else $error("scaled index offset wrong");

  property p_basedIndex;
    @(posedge mclk) disable iff (sys_rst)
      (validR && !modeBadR && modeR == xag_pkg::XAG_BASED_INDEX)
        |-> offsetAddress == baseVal + indexVal;
  endproperty
  a_basedIndex: assert property (p_basedIndex) else $error("based index offset wrong");

  property p_badMode;
    @(posedge mclk) disable iff (sys_rst)
      (validR && modeBadR) |-> (badMode && offsetAddress == 32'h0000_0000);
  endproperty
  a_badMode: assert property (p_badMode) else $error("illegal mode not flagged");

  property p_ioPort;
    @(posedge mclk) disable iff (sys_rst)
      (validR && ioR) |-> (ioPort == offsetAddress[15:0]);
  endproperty
  a_ioPort: assert property (p_ioPort) else $error("port number wrong");

  property p_ioIdle;
    @(posedge mclk) disable iff (sys_rst)
      !ioR |-> (ioPort == 16'h0000);
  endproperty
  a_ioIdle: assert property (p_ioIdle) else $error("port number on memory access");

  property p_byteLane;
    @(posedge mclk) disable iff (sys_rst)
      (validR && sizeR == `XAG_SIZE_BYTE) |-> $onehot(byteEnable);
  endproperty
  a_byteLane: assert property (p_byteLane) else $error("byte access not one lane");

  property p_lowLane;
    @(posedge mclk) disable iff (sys_rst)
      (validR && physAddr[1:0] == 2'h0) |-> byteEnable[0];
  endproperty
  a_lowLane: assert property (p_lowLane) else $error("lowest lane missing");

  property p_resIdle;
    @(posedge mclk) disable iff (sys_rst)
      !reqValid |=> !resValid;
  endproperty
  a_resIdle: assert property (p_resIdle) else $error("result without request");
endmodule
`default_nettype wire

// >>> verification/xag_pipe_model.sv
// integer pipeline model: owns register and selector writes into the block
`timescale 1ns/1ps
`default_nettype none
module xag_pipe_model (
  // clock
  input wire logic mclk,
  // register writes
  output logic gprWrEn,
  output logic [2:0] gprWrIdx,
  output logic [31:0] gprWrData,
  // selector loads
  output logic segLoad,
  output logic [2:0] segLoadIdx,
  output logic [15:0] segLoadSel,
  output logic [31:0] segLoadBase,
  output logic [31:0] segLoadLimit,
  output logic [11:0] segLoadAttr
);
  logic [31:0] gpr[8];
  logic [15:0] sel[8];
  logic [31:0] base[8];
  initial begin
    {gprWrEn, gprWrIdx, gprWrData} = '0;
    {segLoad, segLoadIdx, segLoadSel, segLoadBase, segLoadLimit, segLoadAttr} = '0;
    foreach (gpr[k]) gpr[k] = '0;
  end
  task automatic put_gpr(input logic [2:0] i, input logic [31:0] d);
    @(negedge mclk);
    {gprWrEn, gprWrIdx, gprWrData} = {1'b1, i, d};
    @(negedge mclk);
    gprWrEn = 1'b0;
    gprWrData = ~d;
    gpr[i] = d;
  endtask
  // descriptor fetch result arrives together with the selector
  task automatic put_seg(input logic [2:0] s, input logic [15:0] v, input logic [31:0] b);
    @(negedge mclk);
    {segLoad, segLoadIdx, segLoadSel, segLoadBase} = {1'b1, s, v, b};
    segLoadLimit = ~b;
    segLoadAttr = b[11:0];
    @(negedge mclk);
    segLoad = 1'b0;
    sel[s] = v;
    base[s] = b;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_x86_address_generation.sv
// self-checking bench for the address generation datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_x86_address_generation;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic gprWrEn, segLoad;
  logic [2:0] gprWrIdx, segLoadIdx;
  logic [31:0] gprWrData, segLoadBase, segLoadLimit;
  logic [15:0] segLoadSel;
  logic [11:0] segLoadAttr;
  logic reqValid = 1'b0, ioAccess = 1'b0, protMode = 1'b0, pagingEn = 1'b0;
  logic [3:0] reqMode = '0;
  logic [2:0] baseIdx = '0, indexIdx = '0, segIdx = '0;
  logic [1:0] scaleSel = '0, accSize = '0;
  logic [31:0] displacementValue = '0;
  logic resValid, toPaging, badMode;
  logic [31:0] offsetAddress, linearAddr, physAddr, curLimit;
  logic [3:0] byteEnable;
  logic [15:0] ioPort, curSelector;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  logic [31:0] rnd = 32'h1873;
  logic [165:0] expQ[$];
  logic [165:0] e;
  always #5 mclk = ~mclk;
  xag_pipe_model PM (.mclk(mclk), .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx), .gprWrData(gprWrData),
    .segLoad(segLoad), .segLoadIdx(segLoadIdx), .segLoadSel(segLoadSel), .segLoadBase(segLoadBase),
    .segLoadLimit(segLoadLimit), .segLoadAttr(segLoadAttr));
  xag_addr_gen DUT (.mclk(mclk), .sys_rst(sys_rst), .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx),
    .gprWrData(gprWrData), .segLoad(segLoad), .segLoadIdx(segLoadIdx), .segLoadSel(segLoadSel),
    .segLoadBase(segLoadBase), .segLoadLimit(segLoadLimit), .segLoadAttr(segLoadAttr),
    .reqValid(reqValid), .reqMode(reqMode), .baseIdx(baseIdx), .indexIdx(indexIdx),
    .scaleSel(scaleSel), .displacementValue(displacementValue), .segIdx(segIdx), .accSize(accSize),
    .ioAccess(ioAccess), .protMode(protMode), .pagingEn(pagingEn), .resValid(resValid),
    .offsetAddress(offsetAddress), .linearAddr(linearAddr), .physAddr(physAddr), .toPaging(toPaging),
    .byteEnable(byteEnable), .ioPort(ioPort), .badMode(badMode), .curSelector(curSelector),
    .curLimit(curLimit));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // drives one request per falling edge, so calls in a row are back to back
  task automatic req(input logic [3:0] m, input logic [2:0] b, i, s, input logic [1:0] sc, sz,
                     input logic [31:0] d, input logic pm, pg);
    logic hb, hi, hd, bad;
    logic [31:0] off, ph, lin;
    logic [3:0] be;
    bad = m > 4'h8;
    hb = m inside {1, 2, 5, 6, 7, 8};
    hi = m inside {3, 4, 5, 6, 7, 8};
    hd = m inside {0, 2, 3, 4, 7, 8};
    off = (hb ? PM.gpr[b] : 32'h0) + (hd ? d : 32'h0)
      + ((hi && i != 3'h4) ? PM.gpr[i] << (m inside {4, 6, 8} ? sc : 2'h0) : 32'h0);
    if (bad) off = '0;
    if (!pm) lin = 32'({PM.sel[s], 4'h0}) + 32'(off[15:0]);
    else lin = PM.base[s] + off;
    ph = (pm && pg) ? 32'h0 : lin;
    be = 4'((sz == 2'h0 ? 7'h1 : sz == 2'h1 ? 7'h3 : 7'hf) << ph[1:0]);
    expQ.push_back({~PM.base[s], lin, d[0] ? off[15:0] : 16'h0, bad, pm & pg, be, PM.sel[s], ph, off});
    @(negedge mclk);
    {reqValid, reqMode, baseIdx, indexIdx, segIdx, scaleSel, accSize} = {1'b1, m, b, i, s, sc, sz};
    {displacementValue, protMode, pagingEn, ioAccess} = {d, pm, pg, d[0]};
  endtask
  always @(negedge mclk) begin
    if (!sys_rst && resValid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK(resValid, 1'b0)
      end else begin
        e = expQ.pop_front();
        `CHK(offsetAddress, e[31:0])
        `CHK(badMode, e[85])
        `CHK(curSelector, e[79:64])
        `CHK(curLimit, e[165:134])
        if (!e[85]) begin
          `CHK(physAddr, e[63:32])
          `CHK(toPaging, e[84])
          `CHK(byteEnable, e[83:80])
          `CHK(linearAddr, e[133:102])
          `CHK(ioPort, e[101:86])
        end
      end
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    for (int s = 0; s < 6; s++) begin
      rnd = lfsr_next(rnd);
      PM.put_seg(3'(s), rnd[15:0], rnd ^ 32'h5a5a0000);
    end
    for (int g = 0; g < 8; g++) begin
      rnd = lfsr_next(rnd);
      PM.put_gpr(3'(g), rnd);
    end
    // every mode, scale and address mode in one unbroken stream of requests
    for (int m = 0; m < 10; m++) begin
      for (int k = 0; k < 12; k++) begin
        rnd = lfsr_next(rnd);
        req(4'(m), rnd[2:0], (k == 11) ? 3'h4 : rnd[5:3], 3'(rnd[9:6] % 6), 2'(k), 2'(k % 3), rnd,
            k > 3, k > 7);
      end
    end
    req(4'hf, 3'h0, 3'h0, 3'h0, 2'h0, 2'h0, 32'h0, 1'b0, 1'b0);
    @(negedge mclk);
    reqValid = 1'b0;
    // real mode carry past one megabyte, then protected wrap past the top
    PM.put_seg(3'h0, 16'hffff, 32'h0);
    PM.put_seg(3'h1, 16'h0008, 32'hfffffff0);
    PM.put_gpr(3'h0, 32'h0000ffff);
    PM.put_gpr(3'h1, 32'h00000020);
    req(4'h1, 3'h0, 3'h0, 3'h0, 2'h0, 2'h1, 32'h0, 1'b0, 1'b0);
    req(4'h1, 3'h1, 3'h0, 3'h1, 2'h0, 2'h2, 32'h0, 1'b1, 1'b0);
    req(4'h0, 3'h0, 3'h0, 3'h0, 2'h0, 2'h0, 32'hffffffff, 1'b0, 1'b0);
    @(negedge mclk);
    reqValid = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(expQ.size(), 0)
    test_done();
  end
endmodule
`default_nettype wire
